//--- design/modbus_rtu_pkg.sv
// Shared constants, types and CRC helper for the Modbus-RTU slave framer
package modbus_rtu_pkg;

    // Address and function codes
    localparam logic [7:0]  ADDR_BCAST    = 8'h00;
    localparam logic [7:0]  ADDR_MAX      = 8'hF7;
    localparam logic [7:0]  FUNC_READ     = 8'h03;
    localparam logic [7:0]  FUNC_WRITE    = 8'h06;

    // CRC-16 preset and reflected polynomial
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'hA001;

    // Frame layout: address, function, CRC low, CRC high
    localparam logic [7:0]  MIN_FRAME_LEN = 8'h04;
    localparam logic [7:0]  HDR_CRC_LEN   = 8'h04;

    // Character layout
    localparam logic [3:0]  DATA_BITS     = 4'h8;
    localparam logic [3:0]  CHAR_BITS_NP  = 4'hA;
    localparam logic [3:0]  CHAR_BITS_P   = 4'hB;

    // Parity modes on i_parity
    localparam logic [1:0]  PAR_NONE      = 2'h0;
    localparam logic [1:0]  PAR_EVEN      = 2'h1;
    localparam logic [1:0]  PAR_ODD       = 2'h2;

    // Widths
    localparam int          BIT_W         = 16;
    localparam int          CNT_W         = 24;

    // Transmit byte source
    localparam logic [1:0]  SRC_FIFO      = 2'h0;
    localparam logic [1:0]  SRC_CRC_LO    = 2'h1;
    localparam logic [1:0]  SRC_CRC_HI    = 2'h2;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } tx_state_t;

    // One byte through the CRC: xor in, eight reflected shifts
    function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                             input logic [7:0]  b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

endpackage : modbus_rtu_pkg

//--- design/modbus_rtu_slave_framer.sv
// Modbus-RTU slave framer with transmit FIFO and RS-485 line control
// Functional notes
// - Half duplex; only one side drives.
// - Slave transmits only in reply.
// - Addresses 0 to 247, zero broadcasts.
// - Process frame only for own or broadcast.
// - Broadcast frames get no reply.
// - Unicast frames with a good CRC always open a reply.
// - Receive error or bad request gives fault.
// - Sender waits 3.5 characters silence first.
// - 3.5 characters silence ends a frame.
// - Silence measured continuously, even when idle.
// - Gap over 1.5 characters flushes frame.
// - Short gap appends bytes, CRC then fails.
// - Function 03H reads, 06H writes.
// - Data field holds whole 16-bit words.
// - CRC sent low byte then high.
// - CRC preset FFFF, reflected poly A001.
// - Only eight data bits enter CRC.
// - Parity mismatch is a communication error.
`timescale 1ns/1ps

// Synchronous FIFO with registered flags
module tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("tx_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign push   = i_valid && o_ready;
    assign pop    = o_valid && i_ready;
    assign o_data = mem[rd_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage; no reset needed on the data array
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wr_q] <= i_data;
        end
    end

    // Pointers and flags registered from the next count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            o_ready <= 1'b0;
            o_valid <= 1'b0;
        end else if (i_ce) begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
            cnt_q   <= cnt_d;
            o_ready <= (cnt_d != DEPTH[AW:0]);
            o_valid <= (cnt_d != '0);
        end
    end
endmodule : tx_fifo

// Slave framer top
module modbus_rtu_slave_framer #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                               i_clk,
    input  wire logic                               i_rst,
    input  wire logic                               i_ce,
    input  wire logic                               i_rx,
    output logic                                    o_tx,
    output logic                                    o_tx_oe_n,
    input  wire logic [modbus_rtu_pkg::BIT_W-1:0]   i_bit_cycles,
    input  wire logic [1:0]                         i_parity,
    input  wire logic [7:0]                         i_own_addr,
    output logic      [7:0]                         o_rx_data,
    output logic                                    o_rx_valid,
    output logic                                    o_rx_first,
    output logic                                    o_frame_done,
    output logic                                    o_frame_fault,
    output logic                                    o_frame_bcast,
    output logic      [7:0]                         o_func,
    output logic                                    o_reply_open,
    input  wire logic [7:0]                         i_tx_data,
    input  wire logic                               i_tx_last,
    input  wire logic                               i_tx_valid,
    output logic                                    o_tx_ready
);
    import modbus_rtu_pkg::*;

    if (FIFO_DEPTH < 8) begin : g_bad_fifo
        $error("modbus_rtu_slave_framer: FIFO_DEPTH below 8");
    end

    logic             rx_m_q, rx_s_q;
    rx_state_t        rx_st;
    tx_state_t        tx_st;
    logic [BIT_W-1:0] rx_cnt_q, tx_cnt_q;
    logic [3:0]       rx_bit_q, tx_bit_q;
    logic [7:0]       rx_sh_q, tx_sh_q;
    logic             rx_perr_q, byte_v_q, byte_err_q;
    logic [7:0]       byte_q;
    logic [CNT_W-1:0] sil_q, t15_q, t35_q, char_cyc, gap_q;
    logic             in_frame_q, accept_q, bcast_q, err_q;
    logic [7:0]       len_q, func_q;
    logic [15:0]      rx_crc_q, tx_crc_q;
    logic             grant_q, last_q;
    logic [1:0]       src_q;
    logic             par_on;
    logic             frame_end, crc_ok, func_ok, tx_go, fifo_pop;
    logic [8:0]       fifo_data;
    logic             fifo_valid;

    assign par_on = (i_parity != PAR_NONE);

    // Character length in clocks; a parity bit makes it one bit longer
    assign char_cyc = CNT_W'(i_bit_cycles) *
                      CNT_W'(par_on ? CHAR_BITS_P : CHAR_BITS_NP);

    // Parity bit for a byte in the selected mode
    function automatic logic par_bit(input logic [7:0] b,
                                     input logic [1:0] mode);
        return (mode == PAR_ODD) ? ~^b : ^b;
    endfunction : par_bit

    // Pin synchroniser; only rx_s_q is read by logic
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else if (i_ce) begin
            rx_m_q <= i_rx;
            rx_s_q <= rx_m_q;
        end
    end

    // Character-time thresholds, rebuilt from the live configuration
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            t15_q <= '0;
            t35_q <= '0;
        end else if (i_ce) begin
            t15_q <= char_cyc + (char_cyc >> 1);
            t35_q <= (char_cyc << 1) + char_cyc + (char_cyc >> 1);
        end
    end

    // Character receiver; muted while this end drives the line
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_st      <= RX_IDLE;
            rx_cnt_q   <= '0;
            rx_bit_q   <= '0;
            rx_sh_q    <= '0;
            rx_perr_q  <= 1'b0;
            byte_v_q   <= 1'b0;
            byte_err_q <= 1'b0;
            byte_q     <= '0;
        end else if (i_ce) begin
            byte_v_q <= 1'b0;
            if (rx_st != RX_IDLE && rx_cnt_q != '0) begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end else begin
                rx_cnt_q <= i_bit_cycles - 1'b1;
                unique case (rx_st)
                    RX_IDLE: begin
                        if (!rx_s_q && o_tx_oe_n) begin
                            rx_st    <= RX_START;
                            rx_cnt_q <= i_bit_cycles >> 1;
                        end
                    end
                    RX_START: begin
                        rx_st     <= rx_s_q ? RX_IDLE : RX_DATA;
                        rx_bit_q  <= '0;
                        rx_perr_q <= 1'b0;
                    end
                    RX_DATA: begin
                        rx_sh_q  <= {rx_s_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == DATA_BITS - 1'b1) begin
                            rx_st <= par_on ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        rx_perr_q <= (rx_s_q != par_bit(rx_sh_q, i_parity));
                        rx_st     <= RX_STOP;
                    end
                    RX_STOP: begin
                        byte_v_q   <= 1'b1;
                        byte_q     <= rx_sh_q;
                        byte_err_q <= rx_perr_q || !rx_s_q;
                        rx_st      <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Silence timer: runs at all times, cleared by any line activity
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sil_q <= '0;
        end else if (i_ce) begin
            if (rx_st != RX_IDLE || !o_tx_oe_n) begin
                sil_q <= '0;
            end else if (sil_q != '1) begin
                sil_q <= sil_q + 1'b1;
            end
        end
    end

    // Gap ahead of the byte in flight; the silence timer itself is cleared
    // by that byte's start bit, so it cannot judge the gap afterwards
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_q <= '0;
        end else if (i_ce && rx_st == RX_IDLE) begin
            gap_q <= sil_q;
        end
    end

    assign frame_end = in_frame_q && !byte_v_q && rx_st == RX_IDLE &&
                       sil_q >= t35_q;
    assign crc_ok    = rx_crc_q == 16'h0000 && len_q >= MIN_FRAME_LEN;
    assign func_ok   = func_q == FUNC_READ || func_q == FUNC_WRITE;

    // Frame assembly, address filter and end-of-frame verdict
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_frame_q    <= 1'b0;
            accept_q      <= 1'b0;
            bcast_q       <= 1'b0;
            err_q         <= 1'b0;
            len_q         <= '0;
            func_q        <= '0;
            rx_crc_q      <= CRC_INIT;
            o_rx_data     <= '0;
            o_rx_valid    <= 1'b0;
            o_rx_first    <= 1'b0;
            o_frame_done  <= 1'b0;
            o_frame_fault <= 1'b0;
            o_frame_bcast <= 1'b0;
            o_func        <= '0;
        end else if (i_ce) begin
            o_rx_valid   <= 1'b0;
            o_rx_first   <= 1'b0;
            o_frame_done <= 1'b0;
            if (byte_v_q) begin
                if (!in_frame_q || gap_q > t15_q) begin
                    // Fresh address field; a stale partial is lost
                    in_frame_q <= 1'b1;
                    len_q      <= 8'h01;
                    rx_crc_q   <= crc_byte(CRC_INIT, byte_q);
                    err_q      <= byte_err_q;
                    bcast_q    <= byte_q == ADDR_BCAST;
                    accept_q   <= byte_q == ADDR_BCAST ||
                                  (byte_q == i_own_addr &&
                                   i_own_addr <= ADDR_MAX);
                    o_rx_first <= 1'b1;
                    o_rx_valid <= byte_q == ADDR_BCAST ||
                                  (byte_q == i_own_addr &&
                                   i_own_addr <= ADDR_MAX);
                end else begin
                    // Short gap: bytes join the open frame
                    if (len_q != 8'hFF) len_q <= len_q + 1'b1;
                    if (len_q == 8'h01) func_q <= byte_q;
                    rx_crc_q   <= crc_byte(rx_crc_q, byte_q);
                    err_q      <= err_q || byte_err_q;
                    o_rx_valid <= accept_q;
                end
                o_rx_data <= byte_q;
            end else if (frame_end) begin
                in_frame_q <= 1'b0;
                if (accept_q && crc_ok) begin
                    o_frame_done  <= 1'b1;
                    o_frame_bcast <= bcast_q;
                    o_func        <= func_q;
                    o_frame_fault <= err_q || !func_ok ||
                                     (len_q - HDR_CRC_LEN) % 2 != 0;
                end
            end
        end
    end

    // Reply permission: one response per unicast frame, none for broadcast
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            grant_q      <= 1'b0;
            o_reply_open <= 1'b0;
        end else if (i_ce) begin
            if (o_frame_done && !o_frame_bcast) begin
                grant_q      <= 1'b1;
                o_reply_open <= 1'b1;
            end else if (tx_st == TX_STOP && tx_cnt_q == '0 &&
                         src_q == SRC_CRC_HI) begin
                grant_q      <= 1'b0;
                o_reply_open <= 1'b0;
            end
        end
    end

    // Response bytes wait here; without a grant the FIFO fills and stalls
    tx_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_data  ({i_tx_last, i_tx_data}),
        .i_valid (i_tx_valid),
        .o_ready (o_tx_ready),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop)
    );

    assign tx_go = grant_q && fifo_valid && rx_st == RX_IDLE &&
                   !in_frame_q && sil_q >= t35_q;
    assign fifo_pop = i_ce && fifo_valid &&
                      ((tx_st == TX_IDLE && tx_go) ||
                       (tx_st == TX_STOP && tx_cnt_q == '0 &&
                        src_q == SRC_FIFO && !last_q));

    // Character transmitter and driver enable
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st     <= TX_IDLE;
            tx_cnt_q  <= '0;
            tx_bit_q  <= '0;
            tx_sh_q   <= '0;
            tx_crc_q  <= CRC_INIT;
            src_q     <= SRC_FIFO;
            last_q    <= 1'b0;
            o_tx      <= 1'b1;
            o_tx_oe_n <= 1'b1;
        end else if (i_ce) begin
            if (tx_st != TX_IDLE && tx_cnt_q != '0) begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end else begin
                tx_cnt_q <= i_bit_cycles - 1'b1;
                unique case (tx_st)
                    TX_IDLE: begin
                        o_tx_oe_n <= 1'b1;
                        o_tx      <= 1'b1;
                        if (tx_go) begin
                            tx_sh_q   <= fifo_data[7:0];
                            last_q    <= fifo_data[8];
                            tx_crc_q  <= crc_byte(CRC_INIT, fifo_data[7:0]);
                            src_q     <= SRC_FIFO;
                            o_tx_oe_n <= 1'b0;
                            o_tx      <= 1'b0;
                            tx_st     <= TX_START;
                        end
                    end
                    TX_START: begin
                        o_tx     <= tx_sh_q[0];
                        tx_bit_q <= 4'h1;
                        tx_st    <= TX_DATA;
                    end
                    TX_DATA: begin
                        if (tx_bit_q == DATA_BITS) begin
                            o_tx  <= par_on ? par_bit(tx_sh_q, i_parity)
                                            : 1'b1;
                            tx_st <= par_on ? TX_PAR : TX_STOP;
                        end else begin
                            o_tx     <= tx_sh_q[tx_bit_q[2:0]];
                            tx_bit_q <= tx_bit_q + 1'b1;
                        end
                    end
                    TX_PAR: begin
                        o_tx  <= 1'b1;
                        tx_st <= TX_STOP;
                    end
                    TX_STOP: begin
                        // Next character follows the stop bit at once
                        o_tx  <= 1'b0;
                        tx_st <= TX_START;
                        if (src_q == SRC_CRC_HI) begin
                            o_tx      <= 1'b1;
                            o_tx_oe_n <= 1'b1;
                            tx_st     <= TX_IDLE;
                        end else if (src_q == SRC_FIFO && last_q) begin
                            tx_sh_q <= tx_crc_q[7:0];
                            src_q   <= SRC_CRC_LO;
                        end else if (src_q == SRC_CRC_LO) begin
                            tx_sh_q <= tx_crc_q[15:8];
                            src_q   <= SRC_CRC_HI;
                        end else if (fifo_valid) begin
                            tx_sh_q  <= fifo_data[7:0];
                            last_q   <= fifo_data[8];
                            tx_crc_q <= crc_byte(tx_crc_q, fifo_data[7:0]);
                        end else begin
                            // Host ran dry: hold the line at mark
                            o_tx     <= 1'b1;
                            tx_st    <= TX_STOP;
                            tx_cnt_q <= '0;
                        end
                    end
                endcase
            end
        end
    end

    // Checks
    AST_HALF_DUPLEX: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_tx_oe_n |-> rx_st == RX_IDLE)
        else $error("receiver active while driving the line");
    AST_TX_ONLY_GRANTED: assert property (@(posedge i_clk)
        disable iff (i_rst) $fell(o_tx_oe_n) |-> grant_q)
        else $error("transmission started without a query");
    AST_TX_SILENCE: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_tx_oe_n) |-> $past(sil_q) >= $past(t35_q))
        else $error("reply started before 3.5 character silence");
    AST_BCAST_NO_REPLY: assert property (@(posedge i_clk)
        disable iff (i_rst) o_frame_done && o_frame_bcast && !grant_q
        |=> !grant_q)
        else $error("broadcast frame opened a reply");
    AST_UNICAST_REPLY: assert property (@(posedge i_clk)
        disable iff (i_rst) o_frame_done && !o_frame_bcast && i_ce
        |=> grant_q && o_reply_open)
        else $error("unicast frame left without a reply grant");
    AST_CRC_DROP: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && frame_end && !crc_ok |=> !o_frame_done)
        else $error("frame with bad CRC was reported");
    AST_FLUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && byte_v_q && in_frame_q && gap_q > t15_q
        |=> len_q == 8'h01)
        else $error("partial frame not flushed after long gap");
    AST_ADDR_FILTER: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rx_valid |-> accept_q)
        else $error("byte of a foreign frame was passed on");
    AST_BAD_FUNC_FAULT: assert property (@(posedge i_clk)
        disable iff (i_rst) o_frame_done && o_func != FUNC_READ &&
        o_func != FUNC_WRITE |-> o_frame_fault)
        else $error("unknown function not marked as fault");
    AST_CRC_ORDER: assert property (@(posedge i_clk) disable iff (i_rst)
        src_q == SRC_CRC_LO && $changed(src_q)
        |=> src_q != SRC_FIFO)
        else $error("CRC bytes sent out of order");

    COV_UNICAST_OK: cover property (@(posedge i_clk)
        o_frame_done && !o_frame_bcast && !o_frame_fault);
    COV_BCAST: cover property (@(posedge i_clk)
        o_frame_done && o_frame_bcast);
    COV_FAULT: cover property (@(posedge i_clk)
        o_frame_done && o_frame_fault);
    COV_REPLY_SENT: cover property (@(posedge i_clk) $rose(o_tx_oe_n));
endmodule : modbus_rtu_slave_framer

//--- testbench/rtu_master_model.sv
// Bus master model that drives the slave's receive line
`timescale 1ns/1ps
module rtu_master_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_bit,
    input  wire logic        i_oe_n,
    input  wire logic        i_tx,
    output logic             o_line
);
    logic [7:0] q[$];
    logic       drv = 1'b1;
    // Master lets go while the slave drives, so only one party talks
    assign o_line = i_oe_n ? drv : i_tx;
    // Data bits only, preset FFFF, reflected poly A001
    function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] b);
        c = c ^ {8'h00, b};
        repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        return c;
    endfunction : crc8
    // One character, LSB first, no parity
    task automatic bits(input logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            drv = f[i];
            repeat (i_bit) @(posedge i_clk);
            #1;
        end
    endtask : bits
    // Whole queue back to back, CRC low then high; bad flips one bit
    task automatic send(input logic bad, input logic add_crc);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) c = crc8(c, q[i]);
        c[0] = c[0] ^ bad;
        if (add_crc) begin
            q.push_back(c[7:0]);
            q.push_back(c[15:8]);
        end
        foreach (q[i]) bits({1'b1, q[i], 1'b0});
        q.delete();
    endtask : send
endmodule : rtu_master_model

//--- testbench/modbus_rtu_slave_framer_tb_top.sv
// Self-checking bench for the slave framer
`timescale 1ns/1ps
module modbus_rtu_slave_framer_tb_top;
    import modbus_rtu_pkg::*;
    localparam int CH = 40;
    logic       i_clk = 1'b0, i_rst = 1'b1, rx, o_tx, o_tx_oe_n;
    logic [7:0] o_rx_data, o_func, tx_data = 8'h00;
    logic       o_rx_valid, o_rx_first, o_frame_done, o_frame_fault;
    logic       o_frame_bcast, o_reply_open, o_tx_ready;
    logic       tx_last = 1'b0, tx_valid = 1'b0;
    logic [9:0] exp_q[$];
    logic [8:0] adr_q[$];
    logic [31:0] lfsr = 32'h0C96A978;
    int         num_errors = 0, cmp_count = 0, cyc = 0;
    modbus_rtu_slave_framer dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(1'b1), .i_rx(rx), .o_tx(o_tx), .o_tx_oe_n(o_tx_oe_n),
        .i_bit_cycles(16'h0004), .i_parity(PAR_NONE),
        .i_own_addr(8'h11), .o_rx_data(o_rx_data),
        .o_rx_valid(o_rx_valid), .o_rx_first(o_rx_first),
        .o_frame_done(o_frame_done), .o_frame_fault(o_frame_fault),
        .o_frame_bcast(o_frame_bcast), .o_func(o_func),
        .o_reply_open(o_reply_open), .i_tx_data(tx_data),
        .i_tx_last(tx_last), .i_tx_valid(tx_valid),
        .o_tx_ready(o_tx_ready));
    rtu_master_model m (.i_clk(i_clk), .i_bit(16'h0004),
        .i_oe_n(o_tx_oe_n), .i_tx(o_tx), .o_line(rx));
    // Free-running clock
    always #4 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // Sends a frame with random payload; bad[0] spoils CRC, bad[1] mutes
    task automatic frame(input logic [7:0] a, input logic [7:0] f,
                         input int n, input logic [1:0] bad);
        m.q.push_back(a);
        m.q.push_back(f);
        repeat (n) begin
            lfsr = nxt(lfsr);
            m.q.push_back(lfsr[7:0]);
        end
        if (bad == 2'b00 && (a == 8'h11 || a == ADDR_BCAST))
            exp_q.push_back({(f != FUNC_READ && f != FUNC_WRITE) || n[0],
                             a == ADDR_BCAST, f});
        // Address byte opens a frame unless it joins the previous one
        if (!bad[1]) begin
            adr_q.push_back({a == 8'h11 || a == ADDR_BCAST, a});
        end
        m.send(bad[0], 1'b1);
        repeat (4 * CH) @(posedge i_clk);
        #1;
    endtask : frame
    // Each closed frame consumes the oldest note; a spare one is wrong
    always @(negedge i_clk) begin
        if (o_frame_done === 1'b1) begin
            if (exp_q.size() == 0) check(10'h3FF, 10'h000);
            else check({o_frame_fault, o_frame_bcast, o_func},
                       exp_q.pop_front());
        end
        if (o_rx_first === 1'b1) begin
            if (adr_q.size() == 0) check(10'h3FF, 10'h000);
            else check({1'b0, o_rx_valid, o_rx_data},
                       {1'b0, adr_q.pop_front()});
        end
    end
    // Hang guard well above the planned run length
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            num_errors++;
            finish_test();
        end
    end
    // Main sequence, broadcast first so no reply grant is open yet
    initial begin
        int n;
        logic [7:0]  b;
        logic [15:0] c;
        logic [49:0] got;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        repeat (4 * CH) @(posedge i_clk);
        #1;
        check({9'h000, o_tx_ready}, 10'h001);
        frame(ADDR_BCAST, FUNC_WRITE, 2, 2'b00);
        check({9'h000, o_reply_open}, 10'h000);
        frame(8'h11, FUNC_READ, 4, 2'b00);
        frame(8'h11, FUNC_READ, 4, 2'b01);
        frame(8'h22, FUNC_READ, 4, 2'b00);
        frame(8'h11, 8'h05, 2, 2'b00);
        frame(8'h11, FUNC_WRITE, 3, 2'b00);
        // A second frame one character later merges and fails
        m.q = '{8'h11, 8'h06, 8'h00, 8'h01};
        adr_q.push_back(9'h111);
        m.send(1'b0, 1'b1);
        repeat (CH) @(posedge i_clk);
        #1;
        frame(8'h11, FUNC_WRITE, 2, 2'b10);
        // Partial frame, then a gap past 1.5 characters flushes it
        m.q = '{8'h11, 8'h03};
        adr_q.push_back(9'h111);
        m.send(1'b0, 1'b0);
        repeat (2 * CH) @(posedge i_clk);
        #1;
        frame(8'h11, FUNC_READ, 4, 2'b00);
        // Push a three byte reply; the block appends the CRC
        for (int i = 0; i < 3; i++) begin
            tx_valid = 1'b1;
            tx_data = 8'hA0 + 8'(i);
            tx_last = (i == 2);
            @(posedge i_clk);
            #1;
        end
        tx_valid = 1'b0;
        // Look after the launching edge, never in its own time step
        for (int i = 0; i < 1000 && o_tx_oe_n; i++) begin
            @(posedge i_clk);
            #1;
        end
        check({8'h00, o_tx_oe_n, o_reply_open}, 10'h001);
        n = 0;
        while (o_tx_oe_n === 1'b0 && n < 1000) begin
            // Every reply bit is sampled in its middle
            if (n < 5 * CH && n % (CH / 10) == CH / 20) begin
                got[n / (CH / 10)] = o_tx;
            end
            @(posedge i_clk);
            #1;
            n++;
        end
        c = 16'hFFFF;
        for (int k = 0; k < 3; k++) begin
            c = m.crc8(c, 8'hA0 + 8'(k));
        end
        for (int k = 0; k < 5; k++) begin
            b = (k < 3) ? 8'hA0 + 8'(k) : (k == 3) ? c[7:0] : c[15:8];
            check(got[k * 10 +: 10], {1'b1, b, 1'b0});
        end
        check({9'h000, n >= 5 * CH - 2 && n <= 5 * CH + 2}, 10'h001);
        check({9'h000, o_reply_open}, 10'h000);
        check({9'h000, exp_q.size() == 0 && adr_q.size() == 0},
              10'h001);
        finish_test();
    end
endmodule : modbus_rtu_slave_framer_tb_top
